/* sacr_cfg.svh */
`ifndef SACR_CFG_SVH
`define SACR_CFG_SVH
`define SACR_ADDR_RESULT_LO 16'hFF08
`define SACR_ADDR_RESULT_HI 16'hFF09
`define SACR_ADDR_MODE 16'hFF28
`define SACR_ADDR_CHAN 16'hFF29
`define SACR_MODE_RUN_BIT 7
`define SACR_MODE_TIME_HI 5
`define SACR_MODE_TIME_LO 3
`define SACR_MODE_LV_HI 2
`define SACR_MODE_LV_LO 1
`define SACR_MODE_CMP_BIT 0
`define SACR_MODE_RESET 8'h00
`define SACR_CHAN_RESET 8'h00
`define SACR_RESULT_RESET 16'h0000
`define SACR_HIGH_RESET 8'h00
`define SACR_TIME_MAX 3'h5
`define SACR_LV_LOW 2'h1
`define SACR_STEPS 10
`endif

/* sacr_pkg.sv */
package sacr_pkg;
  typedef enum logic [1:0] {
    SACR_IDLE = 2'b00,
    SACR_SAMPLE = 2'b01,
    SACR_CONVERT = 2'b11
  } sacr_state_t;
  typedef struct packed {
    logic conv_run;
    logic [2:0] time_sel;
    logic [1:0] low_volt_sel;
    logic comparator_on;
  } sacr_mode_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic byte_wr;
    logic [2:0] bit_idx;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sacr_bus_req_t;
endpackage

/* sacr_divider.sv */
`timescale 1ns/100ps
`include "sacr_cfg.svh"
module sacr_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // control
  input wire logic run,
  input wire logic [2:0] time_sel,
  // tick out
  output logic tick
);
  logic [3:0] cnt_reg;
  logic [3:0] div_w;
  logic tick_reg;
  assign div_w = (time_sel == 3'h0) ? 4'hC : (time_sel == 3'h1) ? 4'h8 :
                 (time_sel == 3'h2) ? 4'h6 : (time_sel == 3'h3) ? 4'h4 :
                 (time_sel == 3'h4) ? 4'h3 : 4'h2;
  assign tick = tick_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else if (clk_en) begin
      // conversion clock from peripheral clock
      tick_reg <= run && (cnt_reg == div_w - 4'h1);
      if (!run || cnt_reg == div_w - 4'h1)
        cnt_reg <= 4'h0;
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

/* sacr_top.sv */
// Summary of operation
// - run and comparator bits pick stop, wait or convert; conversion starts at half reference.
// - run set converts regardless of comparator; first result untrusted if comparator was off.
// - every mode register write inserts one wait cycle.
// - voltage code 00 gives dividers 12,8,6,4,3,2 and 264..44 clocks.
// - voltage code 01 keeps dividers, conversion 480..80 clocks.
// - result word holds ten bits left justified, low six bits zero.
// - high byte address holds upper eight, low byte top two bits.
// - reset clears result word.
// - mode or channel writes may disturb results; software reads first.
// - reading either result register inserts one wait cycle.
// - high result byte holds upper eight bits, updated each end, reset clears.
// - channel register low two bits select input 0..3, upper bits zero.
// - channel register accepts bit and byte writes.
// - mode register layout run7, time5:3, volt2:1, comparator0, bit6 zero.
// - completion request pulses at every conversion end.
// - approximation resolves bits from most to least significant.
`timescale 1ns/100ps
`include "sacr_cfg.svh"
module sacr_top
  import sacr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // cpu bus
  input wire sacr_pkg::sacr_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic [15:0] bus_rdata_word,
  output logic bus_wait,
  // analog front end
  input wire logic comparator_out,
  output logic [9:0] dac_code,
  output logic [1:0] analog_sel,
  output logic sample_hold,
  output logic comparator_en,
  // status
  output logic conv_done_irq
);
  sacr_mode_t mode_reg;
  logic [7:0] chan_reg;
  logic [15:0] result_reg;
  logic [7:0] high_reg;
  logic [9:0] sar_reg;
  logic [3:0] bit_reg;
  logic [8:0] cyc_reg;
  logic [8:0] cyc_limit;
  logic done_reg;
  logic wait_reg;
  logic [7:0] rdata_reg;
  logic [15:0] rword_reg;
  logic [2:0] cmp_sync_reg;
  logic cmp_bit_reg;
  sacr_state_t state_reg;
  logic tick;
  logic mode_wr_w, chan_wr_w, res_rd_w, time_ok_w, run_w, restart_w;
  logic [7:0] mode_byte_w, mode_new_w, chan_new_w;

  function automatic logic [7:0] bit_merge(input logic [7:0] old, input sacr_bus_req_t r);
    logic [7:0] v;
    v = old;
    if (r.byte_wr)
      v = r.wdata;
    else
      v[r.bit_idx] = r.wdata[0];
    return v;
  endfunction

  assign mode_wr_w = bus_req.req && bus_req.wr && bus_req.addr == `SACR_ADDR_MODE;
  assign chan_wr_w = bus_req.req && bus_req.wr && bus_req.addr == `SACR_ADDR_CHAN;
  assign res_rd_w = bus_req.req && !bus_req.wr &&
                    (bus_req.addr == `SACR_ADDR_RESULT_LO || bus_req.addr == `SACR_ADDR_RESULT_HI);
  assign mode_byte_w = {mode_reg.conv_run, 1'b0, mode_reg.time_sel, mode_reg.low_volt_sel, mode_reg.comparator_on};
  assign mode_new_w = bit_merge(mode_byte_w, bus_req);
  assign chan_new_w = bit_merge(chan_reg, bus_req) & 8'h03;
  assign time_ok_w = mode_reg.time_sel <= `SACR_TIME_MAX && !mode_reg.low_volt_sel[1];
  assign run_w = mode_reg.conv_run && time_ok_w;
  assign restart_w = chan_wr_w;
  // total conversion clock counts: 264/10 is not whole, so length comes from total cycles
  assign cyc_limit = (mode_reg.low_volt_sel == `SACR_LV_LOW) ?
    ((mode_reg.time_sel == 3'h0) ? 9'd480 : (mode_reg.time_sel == 3'h1) ? 9'd320 :
     (mode_reg.time_sel == 3'h2) ? 9'd240 : (mode_reg.time_sel == 3'h3) ? 9'd160 :
     (mode_reg.time_sel == 3'h4) ? 9'd120 : 9'd80) :
    ((mode_reg.time_sel == 3'h0) ? 9'd264 : (mode_reg.time_sel == 3'h1) ? 9'd176 :
     (mode_reg.time_sel == 3'h2) ? 9'd132 : (mode_reg.time_sel == 3'h3) ? 9'd88 :
     (mode_reg.time_sel == 3'h4) ? 9'd66 : 9'd44);

  sacr_divider u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .run(run_w),
    .time_sel(mode_reg.time_sel),
    .tick(tick)
  );

  assign bus_wait = wait_reg;
  assign bus_rdata = rdata_reg;
  assign bus_rdata_word = rword_reg;
  assign conv_done_irq = done_reg;
  assign dac_code = sar_reg;
  assign analog_sel = chan_reg[1:0];
  assign sample_hold = state_reg == SACR_SAMPLE;
  // comparator powered in wait and convert modes only
  assign comparator_en = mode_reg.comparator_on || mode_reg.conv_run;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= sacr_mode_t'(7'(`SACR_MODE_RESET));
      chan_reg <= `SACR_CHAN_RESET;
    end else if (clk_en) begin
      if (mode_wr_w)
        mode_reg <= sacr_mode_t'({mode_new_w[7], mode_new_w[5:0]});
      if (chan_wr_w)
        chan_reg <= chan_new_w;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rword_reg <= 16'h0000;
    end else if (clk_en) begin
      wait_reg <= (mode_wr_w || chan_wr_w || res_rd_w) && !wait_reg;
      rword_reg <= result_reg;
      unique case (bus_req.addr)
        `SACR_ADDR_RESULT_LO: rdata_reg <= result_reg[7:0];
        `SACR_ADDR_RESULT_HI: rdata_reg <= high_reg;
        `SACR_ADDR_MODE: rdata_reg <= mode_byte_w;
        `SACR_ADDR_CHAN: rdata_reg <= chan_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // comparator crosses from the analog side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmp_sync_reg <= 3'b000;
      cmp_bit_reg <= 1'b0;
    end else if (clk_en) begin
      cmp_sync_reg <= {cmp_sync_reg[1:0], comparator_out};
      if (cmp_sync_reg[2] == cmp_sync_reg[1])
        cmp_bit_reg <= cmp_sync_reg[1];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SACR_IDLE;
      sar_reg <= 10'h000;
      bit_reg <= 4'h0;
      cyc_reg <= 9'd0;
      done_reg <= 1'b0;
      result_reg <= `SACR_RESULT_RESET;
      high_reg <= `SACR_HIGH_RESET;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      if (!run_w || restart_w) begin
        state_reg <= SACR_IDLE;
        cyc_reg <= 9'd0;
      end else begin
        cyc_reg <= cyc_reg + 9'd1;
        unique case (state_reg)
          SACR_IDLE: begin
            state_reg <= SACR_SAMPLE;
            cyc_reg <= 9'd0;
          end
          SACR_SAMPLE: if (tick) begin
            state_reg <= SACR_CONVERT;
            sar_reg <= 10'h200;
            bit_reg <= 4'd9;
          end
          SACR_CONVERT: begin
            if (tick && bit_reg != 4'hF) begin
              sar_reg[bit_reg] <= cmp_bit_reg;
              if (bit_reg != 4'h0)
                sar_reg[bit_reg - 4'h1] <= 1'b1;
              bit_reg <= bit_reg - 4'h1;
            end
            if (cyc_reg >= cyc_limit - 9'd1 && bit_reg == 4'hF) begin
              result_reg <= {sar_reg, 6'h00};
              high_reg <= sar_reg[9:2];
              done_reg <= 1'b1;
              state_reg <= SACR_SAMPLE;
              cyc_reg <= 9'd0;
            end
          end
        endcase
      end
    end
  end

  property p_wait_write;
    @(posedge ref_clk) disable iff (rst) clk_en && mode_wr_w && !wait_reg |=> bus_wait;
  endproperty
  a_wait_write: assert property (p_wait_write) else $error("no wait on mode write");
  property p_wait_read;
    @(posedge ref_clk) disable iff (rst) clk_en && res_rd_w && !wait_reg |=> bus_wait;
  endproperty
  a_wait_read: assert property (p_wait_read) else $error("no wait on result read");
  property p_low_zero;
    @(posedge ref_clk) disable iff (rst) result_reg[5:0] == 6'h00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("result low bits nonzero");
  property p_high_match;
    @(posedge ref_clk) disable iff (rst) high_reg == result_reg[15:8];
  endproperty
  a_high_match: assert property (p_high_match) else $error("high byte mismatch");
  property p_chan_top;
    @(posedge ref_clk) disable iff (rst) chan_reg[7:2] == 6'h00;
  endproperty
  a_chan_top: assert property (p_chan_top) else $error("channel upper bits set");
  property p_idle_bad;
    @(posedge ref_clk) disable iff (rst) !time_ok_w |=> !conv_done_irq;
  endproperty
  a_idle_bad: assert property (p_idle_bad) else $error("conversion on bad code");
  property p_done_pulse;
    @(posedge ref_clk) disable iff (rst) conv_done_irq |=> !conv_done_irq;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  property p_done_load;
    @(posedge ref_clk) disable iff (rst) conv_done_irq |-> result_reg[15:6] == $past(sar_reg);
  endproperty
  a_done_load: assert property (p_done_load) else $error("result not loaded");
  property p_stop;
    @(posedge ref_clk) disable iff (rst) !mode_reg.conv_run && !mode_reg.comparator_on |-> !comparator_en;
  endproperty
  a_stop: assert property (p_stop) else $error("comparator on in stop");
  c_done: cover property (@(posedge ref_clk) disable iff (rst) conv_done_irq);
  c_two: cover property (@(posedge ref_clk) disable iff (rst) conv_done_irq ##[1:600] conv_done_irq);
  c_restart: cover property (@(posedge ref_clk) disable iff (rst) state_reg == SACR_CONVERT && chan_wr_w);
endmodule

/* sacr_afe_model.sv */
`timescale 1ns/100ps
module sacr_afe_model (
  // clock
  input wire logic ref_clk,
  // converter side
  input wire logic [39:0] levels,
  input wire logic [9:0] dac_code,
  input wire logic [1:0] analog_sel,
  input wire logic sample_hold,
  input wire logic comparator_en,
  output logic comparator_out
);
  logic [9:0] held;
  logic flip;
  initial begin
    held = 10'h000;
    flip = 1'b0;
  end
  always @(posedge ref_clk) begin
    flip <= ~flip;
    if (sample_hold) begin
      held <= levels[analog_sel*10 +: 10];
    end
  end
  // a stopped comparator gives noise, never a usable answer
  assign comparator_out = comparator_en ? (held >= dac_code) : flip;
endmodule

/* tb_sacr_top.sv */
`timescale 1ns/100ps
`include "sacr_cfg.svh"
module tb_sacr_top;
  import sacr_pkg::*;
  logic ref_clk, rst, clk_en, bus_wait, comparator_out, sample_hold, comparator_en, conv_done_irq, wt;
  sacr_bus_req_t bus_req;
  logic [7:0] bus_rdata, rd;
  logic [15:0] bus_rdata_word;
  logic [9:0] dac_code;
  logic [1:0] analog_sel;
  logic [39:0] levels;
  int n_errors, checks, gap;
  int tab[12] = '{264, 176, 132, 88, 66, 44, 480, 320, 240, 160, 120, 80};
  assign levels = {10'h001, 10'h2C6, 10'h3FF, 10'h0AB};

  sacr_top i_sacr_top (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rdata_word(bus_rdata_word), .bus_wait(bus_wait),
    .comparator_out(comparator_out), .dac_code(dac_code), .analog_sel(analog_sel),
    .sample_hold(sample_hold), .comparator_en(comparator_en), .conv_done_irq(conv_done_irq));
  sacr_afe_model i_sacr_afe_model (.ref_clk(ref_clk), .levels(levels), .dac_code(dac_code),
    .analog_sel(analog_sel), .sample_hold(sample_hold), .comparator_en(comparator_en),
    .comparator_out(comparator_out));

  task automatic close_out;
    $display("counts checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic bw, input logic [2:0] bi, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{1'b1, wr, bw, bi, a, d};
    @(posedge ref_clk);
    bus_req.req <= 1'b0;
    #1;
    rd = bus_rdata;
    wt = bus_wait;
  endtask
  // cycles from the call to the next completion pulse, bounded
  task automatic wait_done(input int lim);
    gap = 0;
    do begin
      @(posedge ref_clk);
      #1;
      gap++;
      if (gap > lim) begin
        n_errors++;
        $display("mismatch done_wait expected 1 seen 0");
        close_out();
      end
    end while (conv_done_irq !== 1'b1);
  endtask

  task automatic t_reset;
    logic [15:0] adr[4] = '{`SACR_ADDR_RESULT_LO, `SACR_ADDR_RESULT_HI, `SACR_ADDR_MODE, `SACR_ADDR_CHAN};
    check("word_rst", bus_rdata_word, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, 3'h0, adr[i], 8'h00);
      check("reg_rst", rd, 8'h00);
      if (i < 2) check("rd_wait", wt, 1'b1);
    end
    $display("test reset done");
  endtask
  task automatic t_regs;
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h40);
    check("mode_wait", wt, 1'b1);
    acc(1'b0, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h00);
    check("mode_bit6", rd, 8'h00);
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_CHAN, 8'hFF);
    acc(1'b0, 1'b1, 3'h0, `SACR_ADDR_CHAN, 8'h00);
    check("chan_upper", rd, 8'h03);
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_RESULT_HI, 8'hFF);
    check("res_ro", bus_rdata_word, 16'h0000);
    acc(1'b0, 1'b1, 3'h0, 16'hFF2A, 8'h00);
    check("unmapped", rd, 8'h00);
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h2B);
    acc(1'b0, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h00);
    check("mode_fields", rd, 8'h2B);
    check("cmp_wait", {comparator_en, sample_hold}, 2'b10);
    $display("test registers done");
  endtask
  task automatic t_results;
    // comparator has been on far longer than the settling time before run
    repeat (120) @(posedge ref_clk);
    // slowest divider: comparator path needs several clocks per step
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h01);
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h81);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_CHAN, c[7:0]);
      check("chan_wait", wt, 1'b1);
      wait_done(700);
      wait_done(700);
      check("chan_sel", analog_sel, c[1:0]);
      check("word", bus_rdata_word, {levels[c*10 +: 10], 6'h00});
    end
    acc(1'b1, 1'b0, 3'h1, `SACR_ADDR_CHAN, 8'h01);
    wait_done(700);
    wait_done(700);
    acc(1'b0, 1'b1, 3'h0, `SACR_ADDR_CHAN, 8'h00);
    check("chan_bitwr", rd, 8'h03);
    acc(1'b1, 1'b0, 3'h0, `SACR_ADDR_CHAN, 8'h00);
    wait_done(700);
    wait_done(700);
    acc(1'b0, 1'b1, 3'h0, `SACR_ADDR_RESULT_LO, 8'h00);
    check("res_lo", rd, 8'h80);
    check("res_lo_wait", wt, 1'b1);
    acc(1'b0, 1'b1, 3'h0, `SACR_ADDR_RESULT_HI, 8'h00);
    check("res_hi", rd, 8'hB1);
    $display("test results done");
  endtask
  task automatic t_times;
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h01);
    for (int lv = 0; lv < 2; lv++) begin
      for (int c = 5; c >= 0; c--) begin
        // run cleared before the fields change
        acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, {2'b00, c[2:0], lv[1:0], 1'b1});
        acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, {2'b10, c[2:0], lv[1:0], 1'b1});
        wait_done(700);
        wait_done(700);
        check("conv_period", 16'(gap), 16'(tab[lv*6+c]));
        // stop with the same fields before the next change
        acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, {2'b00, c[2:0], lv[1:0], 1'b1});
      end
    end
    $display("test times done");
  endtask
  task automatic t_idle;
    logic busy;
    busy = 1'b0;
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h01);
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'hB1);
    repeat (600) begin
      @(posedge ref_clk);
      #1;
      busy = busy | conv_done_irq | sample_hold;
    end
    check("bad_code_idle", busy, 1'b0);
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h31);
    acc(1'b1, 1'b1, 3'h0, `SACR_ADDR_MODE, 8'h00);
    @(posedge ref_clk);
    #1;
    check("stopped", comparator_en, 1'b0);
    $display("test idle done");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    bus_req = '0;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_results();
    t_times();
    t_idle();
    close_out();
  end
endmodule
